// >>> pkg/rfim_pkg.sv
// Register map and field constants of the receive interrupt enable bank
package rfim_pkg;
    // Ports and register index decode (byte address = 4 x index)
    localparam int          NUM_PORTS    = 4;
    localparam int          IDX_LSB      = 2;
    localparam int          PORT_LSB     = 9;
    localparam logic [10:0] PORT_STRIDE  = 11'h200;
    // Register indices within one port
    localparam logic [8:0]  OFF_SIGSTAT1 = 9'h098;
    localparam logic [8:0]  OFF_SIGSTAT2 = 9'h099;
    localparam logic [8:0]  OFF_SIGSTAT3 = 9'h09A;
    localparam logic [8:0]  OFF_SIGSTAT4 = 9'h09B;
    localparam logic [8:0]  OFF_SUMMARY  = 9'h09F;
    localparam logic [8:0]  OFF_MASK2    = 9'h0A1;
    localparam logic [8:0]  OFF_MASK3    = 9'h0A2;
    localparam logic [8:0]  OFF_MASK4    = 9'h0A3;
    localparam logic [8:0]  OFF_MASK5    = 9'h0A4;
    localparam logic [8:0]  OFF_MASK7    = 9'h0A6;
    localparam logic [8:0]  OFF_SCE1     = 9'h0A8;
    localparam logic [8:0]  OFF_SCE2     = 9'h0A9;
    localparam logic [8:0]  OFF_SCE3     = 9'h0AA;
    localparam logic [8:0]  OFF_SCE4     = 9'h0AB;
    localparam logic [8:0]  OFF_LUPCD1   = 9'h0AC;
    localparam logic [8:0]  OFF_LUPCD2   = 9'h0AD;
    localparam logic [8:0]  OFF_CTRL     = 9'h0F0;
    // Reset value, writable field masks and mode used-bit masks
    localparam logic [7:0]  REG_RST      = 8'h00;
    localparam logic [7:0]  MASK2_WR      = 8'h0F;
    localparam logic [7:0]  MASK3_E1_USED = 8'hBB;
    localparam logic [7:0]  MASK4_WR      = 8'hEF;
    localparam logic [7:0]  MASK5_WR      = 8'h3F;
    localparam logic [7:0]  MASK7_T1_USED = 8'h3F;
    localparam logic [7:0]  MASK7_E1_USED = 8'h03;
    localparam logic [7:0]  MASK2_E1_USED = 8'h03;
    // Control register fields
    localparam int          CTRL_E1_BIT  = 0;
    localparam int          CTRL_LEN_LSB = 4;
    localparam logic [3:0]  PAT_BITS     = 4'h8;
    // Summary bit positions
    localparam int          SUM_SRC2     = 1;
    localparam int          SUM_SRC3     = 2;
    localparam int          SUM_SRC4     = 3;
    localparam int          SUM_SRC5     = 4;
    localparam int          SUM_SRC7     = 6;
    // Bus responses
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage

// >>> rtl/rfim_top.sv
// Receive interrupt enable bank for four framer ports with AXI4-Lite access
// Operation
// - Each enable bit masks its event at zero, passes it at one; reset zero.
// - Bank repeated for four ports at base plus port times fixed stride.
// - T1: third mask holds clear enables bits 7-4, detect enables 3-0.
// - E1: same address enables clock loss, V5.2 link, distant MF alarm.
// - Second mask in E1 enables CRC-4 multiframe bit 1, align frame bit 0.
// - Fourth mask enables elastic store, slip, signaling, timers, multiframe.
// - HDLC mask enables overrun, opening byte, packet end/start, FIFO levels.
// - T1 seventh mask enables RAI-CI, AIS-CI, SLC-96, FDL full, BOC events.
// - E1 seventh mask bit 1 enables Sa6 codeword interrupt.
// - E1 seventh mask bit 0 enables unmasked Sa-bit change interrupt.
// - Per-channel signaling change enables, lowest channel in bit zero.
// - Fourth signaling enable byte, channels 25-32, used only in E1.
// - Writing first loop-up pattern register restarts detector integration.
// - Bit 7 of first loop-up register is the first pattern bit.
// - Length L of 1-7 ignores first register bits below 8 minus L.
// - Second loop-up register ignored for lengths 1 to 7.
// - Channel signaling status latches until read; irq needs fourth mask bit 3.
// - Masked status bits are hidden from the interrupt source summary.
// - Loop-up detected while programmed pattern is being received.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module rfim_top
    import rfim_pkg::*;
#(
    parameter int AW           = 16,
    parameter int LU_INTEG_BIT = 64
) (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              arst_n,
    // AXI4-Lite slave
    input  wire logic [AW-1:0]     s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [AW-1:0]     s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Latched status from the framers, byte per port
    input  wire logic [31:0]       rx_latched_status_2,
    input  wire logic [31:0]       rx_latched_status_3,
    input  wire logic [31:0]       rx_latched_status_4,
    input  wire logic [31:0]       rx_latched_status_5,
    input  wire logic [31:0]       rx_latched_status_7,
    // Signaling change pulses, 32 channels per port
    input  wire logic [127:0]      sig_chg_pulse,
    // Received bit stream per port
    input  wire logic [3:0]        rx_bit,
    input  wire logic [3:0]        rx_bit_en,
    // Interrupt and status outputs
    output logic                   irq_out_n,
    output logic [31:0]            rx_irq_source_summary,
    output logic [3:0]             signaling_change_flag,
    output logic [3:0]             loop_up_restart,
    output logic [3:0]             loop_up_det,
    output logic [3:0]             line_e1
);

    localparam int CNT_W = $clog2(LU_INTEG_BIT + 1);

    logic [3:0][7:0]  en2_r, en3_r, en4_r, en5_r, en7_r;
    logic [3:0][31:0] sce_r;
    logic [3:0][7:0]  lup1_r, lup2_r;
    logic [3:0][2:0]  len_r;
    logic [3:0][31:0] sig_stat_r;
    logic [3:0][15:0] hist_r;
    logic [3:0][CNT_W-1:0] lu_cnt_r;
    logic [3:0][7:0]  hit2, hit3, hit4, hit5, hit7, sum_nxt;

    logic [AW-1:0]    aw_addr_r;
    logic [7:0]       wdat_r;
    logic             wstb_r;
    logic             wr_en, wr_ok, rd_hs, rd_ok;
    logic [1:0]       wr_port, rd_port;
    logic [8:0]       wr_off, rd_off;
    logic [7:0]       rd_byte;

    // Address decode: port from index bit 9 up, register index below
    function automatic logic in_range(input logic [AW-1:0] a);
        in_range = (a >> (IDX_LSB + PORT_LSB + 2)) == '0;
    endfunction

    assign wr_en   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_port = aw_addr_r[IDX_LSB+PORT_LSB +: 2];
    assign wr_off  = aw_addr_r[IDX_LSB +: 9];
    assign rd_hs   = s_axi_arvalid && s_axi_arready;
    assign rd_port = s_axi_araddr[IDX_LSB+PORT_LSB +: 2];
    assign rd_off  = s_axi_araddr[IDX_LSB +: 9];

    always_comb begin
        case (wr_off)
            OFF_MASK2, OFF_MASK3, OFF_MASK4, OFF_MASK5, OFF_MASK7,
            OFF_SCE1, OFF_SCE2, OFF_SCE3, OFF_SCE4,
            OFF_LUPCD1, OFF_LUPCD2, OFF_CTRL: wr_ok = in_range(aw_addr_r);
            default: wr_ok = 1'b0;
        endcase
    end

    // Write address and data may arrive in either order
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            aw_addr_r     <= '0;
            wdat_r        <= REG_RST;
            wstb_r        <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_r     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdat_r       <= s_axi_wdata[7:0];
                wstb_r       <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_en) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            en2_r   <= '0;
            en3_r   <= '0;
            en4_r   <= '0;
            en5_r   <= '0;
            en7_r   <= '0;
            sce_r   <= '0;
            lup1_r  <= '0;
            lup2_r  <= '0;
            len_r   <= '0;
            line_e1 <= '0;
        end else if (wr_en && wr_ok && wstb_r) begin
            case (wr_off)
                OFF_MASK2: en2_r[wr_port] <= wdat_r & MASK2_WR;
                OFF_MASK3: en3_r[wr_port] <= wdat_r;
                OFF_MASK4: en4_r[wr_port] <= wdat_r & MASK4_WR;
                OFF_MASK5: en5_r[wr_port] <= wdat_r & MASK5_WR;
                OFF_MASK7: en7_r[wr_port] <= wdat_r & MASK7_T1_USED;
                OFF_SCE1: sce_r[wr_port][7:0]   <= wdat_r;
                OFF_SCE2: sce_r[wr_port][15:8]  <= wdat_r;
                OFF_SCE3: sce_r[wr_port][23:16] <= wdat_r;
                OFF_SCE4: sce_r[wr_port][31:24] <= wdat_r;
                OFF_LUPCD1: lup1_r[wr_port] <= wdat_r;
                OFF_LUPCD2: lup2_r[wr_port] <= wdat_r;
                OFF_CTRL: begin
                    line_e1[wr_port] <= wdat_r[CTRL_E1_BIT];
                    len_r[wr_port]   <= wdat_r[CTRL_LEN_LSB +: 3];
                end
                default: ;
            endcase
        end
    end

    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            // second-mask events only interrupt in E1
            hit2[p] = line_e1[p] ? rx_latched_status_2[p*8 +: 8] & en2_r[p] & MASK2_E1_USED : REG_RST;
            hit3[p] = rx_latched_status_3[p*8 +: 8] & en3_r[p] & (line_e1[p] ? MASK3_E1_USED : 8'hFF);
            hit4[p] = rx_latched_status_4[p*8 +: 8] & en4_r[p];
            hit5[p] = rx_latched_status_5[p*8 +: 8] & en5_r[p];
            hit7[p] = rx_latched_status_7[p*8 +: 8] & en7_r[p] & (line_e1[p] ? MASK7_E1_USED : MASK7_T1_USED);
            sum_nxt[p] = REG_RST;
            sum_nxt[p][SUM_SRC2] = |hit2[p];
            sum_nxt[p][SUM_SRC3] = |hit3[p];
            sum_nxt[p][SUM_SRC4] = |hit4[p];
            sum_nxt[p][SUM_SRC5] = |hit5[p];
            sum_nxt[p][SUM_SRC7] = |hit7[p];
        end
    end

    // any enabled latched status used in the current line mode pulls the interrupt low
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            irq_out_n             <= 1'b1;
            rx_irq_source_summary <= '0;
        end else begin
            irq_out_n             <= ~(|sum_nxt);
            rx_irq_source_summary <= sum_nxt;
        end
    end

    // Signaling status latches; a new change beats a read clear
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sig_stat_r            <= '0;
            signaling_change_flag <= '0;
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                for (int b = 0; b < 4; b++) begin
                    if (rd_hs && rd_port == p[1:0] && rd_off == OFF_SIGSTAT1 + 9'(b) && in_range(s_axi_araddr))
                        sig_stat_r[p][b*8 +: 8] <= sig_chg_pulse[p*32+b*8 +: 8];
                    else
                        sig_stat_r[p][b*8 +: 8] <= sig_stat_r[p][b*8 +: 8] | sig_chg_pulse[p*32+b*8 +: 8];
                end
                // enabled channels raise the flag; upper byte E1 only
                signaling_change_flag[p] <= |(sig_chg_pulse[p*32 +: 24] & sce_r[p][23:0])
                    || (line_e1[p] && |(sig_chg_pulse[p*32+24 +: 8] & sce_r[p][31:24]));
            end
        end
    end

    // Newest bits must form some rotation of the pattern; one fixed phase would match only once per pattern length
    function automatic logic lu_match(input logic [15:0] h, input logic [7:0] p1,
                                      input logic [7:0] p2, input logic [2:0] len);
        logic [15:0] pat;
        logic        hit;
        int          n;
        pat      = {p1, p2};
        // only the top L bits count, both registers for length zero
        n        = (len == 3'h0) ? $bits(h) : int'(len);
        lu_match = 1'b0;
        // pattern bit 7 is the first bit of the rotation
        for (int k = 0; k < $bits(h); k++) begin
            hit = (k < n);
            for (int i = 0; i < $bits(h); i++)
                if (i < n && h[n-1-i] != pat[15 - ((i + k) % n)])
                    hit = 1'b0;
            lu_match = lu_match | hit;
        end
    endfunction

    // Integration restarts on a first pattern register write or any mismatch
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hist_r          <= '0;
            lu_cnt_r        <= '0;
            loop_up_det     <= '0;
            loop_up_restart <= '0;
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                loop_up_restart[p] <= 1'b0;
                if (wr_en && wr_ok && wr_port == p[1:0] && wr_off == OFF_LUPCD1) begin
                    loop_up_restart[p] <= 1'b1;
                    lu_cnt_r[p]        <= '0;
                    loop_up_det[p]     <= 1'b0;
                end else if (rx_bit_en[p]) begin
                    hist_r[p] <= {hist_r[p][14:0], rx_bit[p]};
                    if (lu_match({hist_r[p][14:0], rx_bit[p]}, lup1_r[p], lup2_r[p], len_r[p])) begin
                        if (lu_cnt_r[p] != CNT_W'(LU_INTEG_BIT))
                            lu_cnt_r[p] <= lu_cnt_r[p] + CNT_W'(1);
                        loop_up_det[p] <= lu_cnt_r[p] >= CNT_W'(LU_INTEG_BIT - 1);
                    end else begin
                        lu_cnt_r[p]    <= '0;
                        loop_up_det[p] <= 1'b0;
                    end
                end
            end
        end
    end

    // Read data mux; full stored byte returned whatever the mode
    always_comb begin
        rd_ok   = in_range(s_axi_araddr);
        rd_byte = REG_RST;
        case (rd_off)
            OFF_SIGSTAT1: rd_byte = sig_stat_r[rd_port][7:0];
            OFF_SIGSTAT2: rd_byte = sig_stat_r[rd_port][15:8];
            OFF_SIGSTAT3: rd_byte = sig_stat_r[rd_port][23:16];
            OFF_SIGSTAT4: rd_byte = sig_stat_r[rd_port][31:24];
            OFF_SUMMARY:  rd_byte = rx_irq_source_summary[rd_port*8 +: 8];
            OFF_MASK2:    rd_byte = en2_r[rd_port];
            OFF_MASK3:    rd_byte = en3_r[rd_port];
            OFF_MASK4:    rd_byte = en4_r[rd_port];
            OFF_MASK5:    rd_byte = en5_r[rd_port];
            OFF_MASK7:    rd_byte = en7_r[rd_port];
            OFF_SCE1:     rd_byte = sce_r[rd_port][7:0];
            OFF_SCE2:     rd_byte = sce_r[rd_port][15:8];
            OFF_SCE3:     rd_byte = sce_r[rd_port][23:16];
            OFF_SCE4:     rd_byte = sce_r[rd_port][31:24];
            OFF_LUPCD1:   rd_byte = lup1_r[rd_port];
            OFF_LUPCD2:   rd_byte = lup2_r[rd_port];
            OFF_CTRL:     rd_byte = {1'b0, len_r[rd_port], 3'h0, line_e1[rd_port]};
            default:      rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (rd_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_ok ? {24'h000000, rd_byte} : 32'h00000000;
            s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    property p_irq_set;
        (|sum_nxt) |=> !irq_out_n;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("enabled status did not raise irq");

    property p_irq_mask;
        (en4_r[1][3] == 1'b0 && rx_latched_status_4[15:8] == 8'h08) |-> !sum_nxt[1][SUM_SRC4];
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked status reached summary");

    property p_e1_rim3;
        (line_e1[0] && (rx_latched_status_3[7:0] & ~MASK3_E1_USED) != 8'h00
            && (rx_latched_status_3[7:0] & MASK3_E1_USED) == 8'h00) |=> !rx_irq_source_summary[SUM_SRC3];
    endproperty
    a_e1_rim3: assert property (p_e1_rim3) else $error("E1 unused bits interrupted");

    property p_summary;
        rx_irq_source_summary[SUM_SRC7] |-> $past(|(rx_latched_status_7[7:0] & en7_r[0]));
    endproperty
    a_summary: assert property (p_summary) else $error("summary bit without enabled cause");

    property p_lu_restart;
        (wr_en && wr_ok && wr_port == 2'h2 && wr_off == OFF_LUPCD1) |=> loop_up_restart[2] && !loop_up_det[2] ##1 !loop_up_restart[2];
    endproperty
    a_lu_restart: assert property (p_lu_restart) else $error("pattern write did not restart");

    property p_lu_det;
        loop_up_det[2] |-> lu_cnt_r[2] >= CNT_W'(LU_INTEG_BIT - 1);
    endproperty
    a_lu_det: assert property (p_lu_det) else $error("loop-up detected before integration");

    property p_sig_flag;
        (sig_chg_pulse[24] && sce_r[0][24] && line_e1[0]) |=> signaling_change_flag[0];
    endproperty
    a_sig_flag: assert property (p_sig_flag) else $error("enabled channel change missed");

    property p_sig_t1;
        (!line_e1[0] && sig_chg_pulse[23:0] == 24'h000000) |=> !signaling_change_flag[0];
    endproperty
    a_sig_t1: assert property (p_sig_t1) else $error("upper channels flagged in T1");

    property p_sig_latch;
        sig_chg_pulse[24] |=> sig_stat_r[0][24] ##1 (sig_stat_r[0][24] || $past(rd_hs));
    endproperty
    a_sig_latch: assert property (p_sig_latch) else $error("signaling status not latched");

    property p_port_wr;
        (wr_en && wr_ok && wstb_r && wr_port == 2'h2 && wr_off == OFF_MASK5) |=> en5_r[2] == $past(wdat_r & MASK5_WR);
    endproperty
    a_port_wr: assert property (p_port_wr) else $error("port copy write lost");

    property p_rd_lat;
        rd_hs |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");

    c_irq: cover property (!irq_out_n ##1 irq_out_n);
    c_lu: cover property (!loop_up_det[2] ##1 loop_up_det[2]);
    c_wr: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY);
    c_sig: cover property (signaling_change_flag[0]);

endmodule // rfim_top

// >>> tb/test_rx_framer_interrupt_masks.sv
// Self-checking bench for the receive interrupt enable bank
`timescale 1ns/1ps
module test_rx_framer_interrupt_masks
    import rfim_pkg::*;
;
    logic         mclk = 0, arst_n = 0;
    logic [15:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic         s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0]  s_axi_wdata = 0;
    logic [3:0]   s_axi_wstrb = 0;
    logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_out_n;
    logic [1:0]   s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0]  s_axi_rdata, rx_irq_source_summary, rd_v;
    logic [31:0]  rx_latched_status_2 = 0, rx_latched_status_3 = 0, rx_latched_status_4 = 0;
    logic [31:0]  rx_latched_status_5 = 0, rx_latched_status_7 = 0;
    logic [127:0] sig_chg_pulse = 0;
    logic [3:0]   rx_bit = 0, rx_bit_en = 0, signaling_change_flag, loop_up_restart, loop_up_det, line_e1;
    int           error_cnt = 0, tests_run = 0, cyc = 0;
    logic         seen;

    always #20 mclk = ~mclk;

    rfim_top #(.AW(16), .LU_INTEG_BIT(4)) dut (.mclk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .rx_latched_status_2, .rx_latched_status_3, .rx_latched_status_4,
        .rx_latched_status_5, .rx_latched_status_7, .sig_chg_pulse, .rx_bit, .rx_bit_en, .irq_out_n,
        .rx_irq_source_summary, .signaling_change_flag, .loop_up_restart, .loop_up_det, .line_e1);

    task automatic results();
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Hang guard, well above the run length
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            results();
        end
    end

    task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wr(int p, logic [8:0] i, logic [7:0] d);
        logic aw, w;
        aw = 1;
        w = 1;
        s_axi_awaddr <= 16'((p * PORT_STRIDE + i) * 4);
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (aw || w) begin
            @(posedge mclk);
            if (aw && s_axi_awready === 1'b1) begin
                aw = 0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready === 1'b1) begin
                w = 0;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(int p, logic [8:0] i);
        s_axi_araddr <= 16'((p * PORT_STRIDE + i) * 4);
        s_axi_arvalid <= 1'b1;
        do @(posedge mclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
        rd_v = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic t_reset();
        logic [8:0] ix[10] = '{OFF_MASK3, OFF_MASK4, OFF_MASK5, OFF_MASK7, OFF_SCE1, OFF_SCE2, OFF_SCE3,
                               OFF_SCE4, OFF_LUPCD1, OFF_LUPCD2};
        foreach (ix[k]) begin
            rd(3, ix[k]);
            chk("reset value", 32'h0, rd_v);
        end
        chk("irq idle", 32'h1, {31'h0, irq_out_n});
    endtask

    task automatic t_rw();
        logic [8:0] ix[4] = '{OFF_MASK3, OFF_MASK4, OFF_MASK5, OFF_MASK7};
        logic [7:0] ev[4] = '{8'hFF, MASK4_WR, MASK5_WR, MASK7_T1_USED};
        foreach (ix[k]) begin
            wr(2, ix[k], 8'hFF);
            rd(2, ix[k]);
            chk("mask readback", {24'h0, ev[k]}, rd_v);
            rd(1, ix[k]);
            chk("other port untouched", 32'h0, rd_v);
        end
    endtask

    task automatic t_irq();
        wr(1, OFF_MASK4, 8'h08);
        rx_latched_status_4[11] <= 1'b1;
        repeat (3) @(posedge mclk);
        chk("irq enabled", 32'h0, {31'h0, irq_out_n});
        chk("summary port", 32'h0000_0800, rx_irq_source_summary);
        rd(1, OFF_SUMMARY);
        chk("summary reg", 32'h08, rd_v);
        wr(1, OFF_MASK4, 8'hF7);
        repeat (3) @(posedge mclk);
        chk("irq masked", 32'h1, {31'h0, irq_out_n});
        chk("summary masked", 32'h0, rx_irq_source_summary);
        rx_latched_status_4[11] <= 1'b0;
    endtask

    task automatic pulse(int b);
        @(posedge mclk) sig_chg_pulse[b] <= 1'b1;
        @(posedge mclk) sig_chg_pulse[b] <= 1'b0;
        seen = 0;
        repeat (3) @(posedge mclk) seen = seen | signaling_change_flag[0];
    endtask

    task automatic t_sig();
        wr(0, OFF_SCE4, 8'h01);
        pulse(24);
        chk("ch25 in T1", 32'h0, {31'h0, seen});
        rd(0, OFF_SIGSTAT4);
        chk("status latched", 32'h01, rd_v);
        rd(0, OFF_SIGSTAT4);
        chk("status read clear", 32'h00, rd_v);
        pulse(25);
        wr(0, OFF_CTRL, 8'h01);
        chk("line mode", 32'h1, {31'h0, line_e1[0]});
        pulse(25);
        chk("ch26 disabled", 32'h0, {31'h0, seen});
        pulse(24);
        chk("ch25 in E1", 32'h1, {31'h0, seen});
    endtask

    task automatic t_e1();
        wr(0, OFF_MASK7, 8'h01);
        rx_latched_status_7[2] <= 1'b1;
        repeat (3) @(posedge mclk);
        chk("E1 unused bit", 32'h1, {31'h0, irq_out_n});
        rx_latched_status_7[0] <= 1'b1;
        repeat (3) @(posedge mclk);
        chk("Sa change irq", 32'h0, {31'h0, irq_out_n});
        rx_latched_status_7 <= 32'h2;
        repeat (3) @(posedge mclk);
        chk("Sa6 masked", 32'h1, {31'h0, irq_out_n});
        wr(0, OFF_MASK7, 8'h02);
        repeat (3) @(posedge mclk);
        chk("Sa6 irq", 32'h0, {31'h0, irq_out_n});
        rx_latched_status_7 <= 32'h0;
        wr(0, OFF_MASK2, 8'h02);
        rx_latched_status_2[1] <= 1'b1;
        repeat (3) @(posedge mclk);
        chk("CRC-4 MF irq", 32'h0, {31'h0, irq_out_n});
        rx_latched_status_2 <= 32'h0;
        wr(0, OFF_MASK3, 8'hFF);
        rx_latched_status_3[6] <= 1'b1;
        repeat (3) @(posedge mclk);
        chk("E1 rim3 bit6", 32'h1, {31'h0, irq_out_n});
        rx_latched_status_3 <= 32'h0;
    endtask

    task automatic feed(int n, logic b);
        repeat (n) begin
            @(posedge mclk) rx_bit[2] <= b;
            rx_bit_en[2] <= 1'b1;
            @(posedge mclk) rx_bit_en[2] <= 1'b0;
        end
        repeat (2) @(posedge mclk);
    endtask

    task automatic t_lu();
        wr(2, OFF_LUPCD1, 8'hD5);
        wr(2, OFF_LUPCD2, 8'h00);
        wr(2, OFF_CTRL, 8'h10);
        feed(6, 1'b1);
        chk("loop-up found", 32'h1, {31'h0, loop_up_det[2]});
        feed(1, 1'b0);
        chk("loop-up lost", 32'h0, {31'h0, loop_up_det[2]});
        feed(6, 1'b1);
        wr(2, OFF_LUPCD1, 8'h7F);
        chk("restart on write", 32'h0, {31'h0, loop_up_det[2]});
        feed(6, 1'b1);
        chk("first bit is bit7", 32'h0, {31'h0, loop_up_det[2]});
        wr(2, OFF_LUPCD1, 8'h80);
        wr(2, OFF_LUPCD2, 8'hFF);
        wr(2, OFF_CTRL, 8'h20);
        repeat (3) begin
            feed(1, 1'b1);
            feed(1, 1'b0);
        end
        chk("two-bit pattern", 32'h1, {31'h0, loop_up_det[2]});
    endtask

    task automatic t_err();
        rd(1, 9'h0B0);
        chk("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, rsp});
        chk("unmapped data", 32'h0, rd_v);
        wr(1, 9'h0B0, 8'h55);
        chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        t_reset();
        t_rw();
        t_irq();
        t_sig();
        t_e1();
        t_lu();
        t_err();
        results();
    end
endmodule // test_rx_framer_interrupt_masks
